// ===== rtl/ebl_boot_loader.sv
// External port boot loader: EPROM master and host slave download
`timescale 1ns/1ps
`default_nettype none
module ebl_boot_loader (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        eprom_boot_select_pin,
    input  wire logic        link_boot_select_pin,
    input  wire logic        boot_memory_select_in,
    output logic             boot_memory_select_out_n,
    output logic             boot_memory_select_oe,
    output logic [3:0]       memory_select_n,
    output logic [23:0]      ext_addr,
    output logic             read_strobe_n,
    input  wire logic [7:0]  ext_data_hi,
    input  wire logic        host_write,
    input  wire logic [15:0] host_data,
    input  wire logic        host_wide,
    output logic             host_ready,
    output logic             mem_write,
    output logic [23:0]      mem_addr,
    output logic [47:0]      mem_data,
    output logic [31:0]      boot_channel_control,
    output logic [23:0]      boot_internal_index,
    output logic [15:0]      boot_internal_count,
    output logic [15:0]      boot_external_count,
    output logic [23:0]      program_counter,
    output logic             boot_channel_interrupt,
    output logic             boot_busy,
    output logic             boot_done,
    output logic [1:0]       boot_mode
);
    typedef struct packed {
        ebl_pkg::ebl_state_type state;
        ebl_pkg::ebl_mode_type  mode;
        logic [31:0]            ctrl;
        logic [23:0]            int_index;
        logic [23:0]            ext_index;
        logic [15:0]            int_count;
        logic [15:0]            ext_count;
        logic [23:0]            pc;
        logic [2:0]             wait_cnt;
        logic [7:0]             byte_hold;
        logic                   byte_valid;
        logic                   rd_n;
        logic                   irq;
        logic                   mem_we;
        logic [47:0]            mem_word;
        logic [23:0]            mem_at;
        logic                   host_wide;
        logic [1:0]             sync_eb;
        logic [1:0]             sync_lb;
        logic [1:0]             sync_bms;
        logic [7:0]             sync_data;
        logic [7:0]             data_meta;
    } ebl_top_state_type;

    ebl_top_state_type st;
    ebl_top_state_type next_st;
    logic              pack_valid;
    logic [47:0]       pack_word;
    logic              pack_in_valid;
    logic [15:0]       pack_in;
    logic              pack_wide;

    // Decrement a count, saturating at zero
    function automatic logic [15:0] dec_count(input logic [15:0] c);
        dec_count = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
    endfunction

    // Host traffic feeds the packer only while slave download runs
    always_comb begin
        pack_in_valid = 1'b0;
        pack_in = 16'h0000;
        pack_wide = 1'b0;
        if (st.state == ebl_pkg::EBL_SLAVE) begin
            pack_in_valid = host_write;
            pack_in = host_data;
            pack_wide = st.host_wide;
        end else if (st.byte_valid) begin
            pack_in_valid = 1'b1;
            pack_in = {8'h00, st.byte_hold};
        end
    end

    ebl_pack u_pack (
        .clk        (clk),
        .srst       (srst),
        .clear      (st.state == ebl_pkg::EBL_IDLE),
        .in_valid   (pack_in_valid),
        .wide       (pack_wide),
        .in_data    (pack_in),
        .word_valid (pack_valid),
        .word       (pack_word)
    );

    // Main sequencer
    always_comb begin
        next_st = st;
        next_st.mem_we = 1'b0;
        next_st.byte_valid = 1'b0;
        // Pins are asynchronous: two flops before anything looks at them
        next_st.sync_eb = {st.sync_eb[0], eprom_boot_select_pin};
        next_st.sync_lb = {st.sync_lb[0], link_boot_select_pin};
        next_st.sync_bms = {st.sync_bms[0], boot_memory_select_in};
        next_st.data_meta = ext_data_hi;
        next_st.sync_data = st.data_meta;
        case (st.state)
            ebl_pkg::EBL_WAIT_MODE: begin
                // Wait for synchronisers to fill after release
                if (st.wait_cnt == 3'h2) begin
                    next_st.state = ebl_pkg::EBL_IDLE;
                    next_st.wait_cnt = 3'h0;
                    if (st.sync_eb[1] && !st.sync_lb[1]) begin
                        next_st.mode = ebl_pkg::EBL_MODE_EPROM;
                        next_st.ctrl = ebl_pkg::CTRL_EPROM;
                        next_st.ext_count = ebl_pkg::BYTE_COUNT;
                        next_st.ext_index = ebl_pkg::EXT_START;
                    end else if (!st.sync_eb[1] && !st.sync_lb[1]
                                 && st.sync_bms[1]) begin
                        next_st.mode = ebl_pkg::EBL_MODE_HOST;
                        next_st.ctrl = ebl_pkg::CTRL_HOST;
                    end else begin
                        // Link, serial and no-boot are not handled here
                        next_st.mode = ebl_pkg::EBL_MODE_NONE;
                        next_st.state = ebl_pkg::EBL_DONE;
                    end
                    next_st.int_index = ebl_pkg::INT_START;
                    next_st.int_count = ebl_pkg::WORD_COUNT;
                end else begin
                    next_st.wait_cnt = st.wait_cnt + 3'h1;
                end
            end
            ebl_pkg::EBL_IDLE: begin
                // One cycle of idle so the packer is cleared
                if (st.mode == ebl_pkg::EBL_MODE_EPROM) begin
                    next_st.state = ebl_pkg::EBL_READ;
                    next_st.rd_n = 1'b0;
                end else begin
                    next_st.state = ebl_pkg::EBL_SLAVE;
                end
            end
            ebl_pkg::EBL_READ: begin
                // Strobe held for the wait states plus one cycle
                if (st.wait_cnt == ebl_pkg::WAIT_STATES) begin
                    next_st.wait_cnt = 3'h0;
                    next_st.rd_n = 1'b1;
                    next_st.byte_hold = st.sync_data;
                    next_st.byte_valid = 1'b1;
                    next_st.ext_index = st.ext_index + 24'h000001;
                    next_st.ext_count = dec_count(st.ext_count);
                    next_st.state = ebl_pkg::EBL_STORE;
                end else begin
                    next_st.wait_cnt = st.wait_cnt + 3'h1;
                end
            end
            ebl_pkg::EBL_STORE: begin
                // Wait until the packer has taken the byte
                if (!st.byte_valid) begin
                    if (st.ext_count == 16'h0000 && st.int_count == 16'h0000)
                    begin
                        next_st.state = ebl_pkg::EBL_DONE;
                        next_st.irq = 1'b1;
                        next_st.pc = ebl_pkg::VECTOR_ADDR;
                    end else if (st.ext_count != 16'h0000) begin
                        next_st.state = ebl_pkg::EBL_READ;
                        next_st.rd_n = 1'b0;
                    end
                end
            end
            ebl_pkg::EBL_SLAVE: begin
                next_st.host_wide = host_wide;
                if (st.int_count == 16'h0000) begin
                    next_st.state = ebl_pkg::EBL_DONE;
                    next_st.irq = 1'b1;
                    next_st.pc = ebl_pkg::VECTOR_ADDR;
                end
            end
            ebl_pkg::EBL_DONE: begin
                next_st.irq = 1'b0; // Interrupt request is one pulse
            end
            default: begin
                next_st.state = ebl_pkg::EBL_WAIT_MODE;
            end
        endcase
        // Completed words go to internal memory at consecutive addresses
        if (pack_valid && st.int_count != 16'h0000) begin
            next_st.mem_we = 1'b1;
            next_st.mem_word = pack_word;
            next_st.mem_at = st.int_index;
            next_st.int_index = st.int_index + 24'h000001;
            next_st.int_count = dec_count(st.int_count);
        end
    end

    // Reset leaves the core idling at the boot idle address
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.state <= ebl_pkg::EBL_WAIT_MODE;
            st.mode <= ebl_pkg::EBL_MODE_NONE;
            st.pc <= ebl_pkg::IDLE_PC;
            st.rd_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Boot select is driven only in EPROM mode until the download ends
    assign boot_busy = st.state != ebl_pkg::EBL_DONE
                    && st.state != ebl_pkg::EBL_WAIT_MODE;
    assign boot_memory_select_oe = st.mode == ebl_pkg::EBL_MODE_EPROM
                                && boot_busy;
    assign boot_memory_select_out_n = st.rd_n;
    assign memory_select_n = 4'hf;
    assign read_strobe_n = st.rd_n;
    assign ext_addr = st.ext_index;
    assign host_ready = st.state == ebl_pkg::EBL_SLAVE;
    assign mem_write = st.mem_we;
    assign mem_addr = st.mem_at;
    assign mem_data = st.mem_word;
    assign boot_channel_control = st.ctrl;
    assign boot_internal_index = st.int_index;
    assign boot_internal_count = st.int_count;
    assign boot_external_count = st.ext_count;
    assign program_counter = st.pc;
    assign boot_channel_interrupt = st.irq;
    assign boot_done = st.state == ebl_pkg::EBL_DONE;
    assign boot_mode = st.mode;
endmodule
`default_nettype wire

// ===== rtl/ebl_pkg.sv
// Constants for the external port boot loader
// Overview of operation
// - Boot pin high, link pin low: EPROM boot, boot select drives chip select.
// - Both boot pins low, boot select input high: host boot, wait as slave.
// - After reset release idle with program counter at 0x40004.
// - EPROM boot: boot select is the only chip select, others held off.
// - EPROM reads asynchronous, seven wait states, strobe lasts 8 cycles.
// - EPROM bytes on data 23..16, six packed per 48-bit word, 256 words.
// - EPROM address starts at 0x800000 and increments after each byte.
// - Words stored at 0x40000 through 0x400FF, then loaded code runs.
// - EPROM boot resets word count to 0x0100, byte count to 0x0600.
// - EPROM boot channel control resets to 0x000561, master mode.
// - Both counts decrement; at zero stop, interrupt, release select, vector.
// - Host boot channel control resets to 0x00000161, slave mode.
// - Host boot sets internal index to first address, count 0x0100.
// - Host boot: count decrements per word; at zero stop, interrupt, vector.
// - Link port boot uses channel 8 nibbles; not built in this block.
package ebl_pkg;
    localparam logic [23:0] IDLE_PC        = 24'h040004;
    localparam logic [23:0] INT_START      = 24'h040000;
    localparam logic [23:0] VECTOR_ADDR    = 24'h040050;
    localparam logic [23:0] EXT_START      = 24'h800000;
    localparam logic [15:0] WORD_COUNT     = 16'h0100;
    localparam logic [15:0] BYTE_COUNT     = 16'h0600;
    localparam logic [31:0] CTRL_EPROM     = 32'h00000561;
    localparam logic [31:0] CTRL_HOST      = 32'h00000161;
    localparam logic [2:0]  WAIT_STATES    = 3'h7;  // Strobe = waits + 1
    localparam logic [2:0]  LAST_BYTE      = 3'h5;  // Six bytes per word
    localparam logic [2:0]  LAST_HALF      = 3'h2;  // Three halves per word
    localparam int          CTRL_MASTER_BIT = 10;

    typedef enum logic [5:0] {
        EBL_WAIT_MODE = 6'h01,
        EBL_IDLE      = 6'h02,
        EBL_READ      = 6'h04,
        EBL_STORE     = 6'h08,
        EBL_SLAVE     = 6'h10,
        EBL_DONE      = 6'h20
    } ebl_state_type;

    typedef enum logic [1:0] {
        EBL_MODE_NONE  = 2'h0,
        EBL_MODE_EPROM = 2'h1,
        EBL_MODE_HOST  = 2'h2
    } ebl_mode_type;
endpackage

// ===== rtl/ebl_pack.sv
// Byte or halfword packer building 48-bit words, least significant first
`timescale 1ns/1ps
`default_nettype none
module ebl_pack (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        clear,
    input  wire logic        in_valid,
    input  wire logic        wide,
    input  wire logic [15:0] in_data,
    output logic             word_valid,
    output logic [47:0]      word
);
    typedef struct packed {
        logic [47:0] word;
        logic [2:0]  pos;
        logic        done;
    } ebl_pack_state_type;

    ebl_pack_state_type st;
    ebl_pack_state_type next_st;

    // Place each piece above the previous ones; done pulses on last piece
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (clear) begin
            next_st.pos = 3'h0;
        end else if (in_valid) begin
            if (wide) begin
                next_st.word[st.pos[1:0] * 16 +: 16] = in_data;
            end else begin
                next_st.word[st.pos * 8 +: 8] = in_data[7:0];
            end
            if (st.pos == (wide ? ebl_pkg::LAST_HALF : ebl_pkg::LAST_BYTE))
            begin
                next_st.pos = 3'h0;
                next_st.done = 1'b1;
            end else begin
                next_st.pos = st.pos + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign word_valid = st.done;
    assign word = st.word;
endmodule
`default_nettype wire

// ===== tb/ebl_boot_loader_properties.sv
// Port checker for the boot loader
`timescale 1ns/1ps
`default_nettype none
module ebl_chk (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        read_strobe_n,
    input wire logic [23:0] ext_addr,
    input wire logic [3:0]  memory_select_n,
    input wire logic        boot_memory_select_out_n,
    input wire logic        boot_memory_select_oe,
    input wire logic [1:0]  boot_mode,
    input wire logic        host_ready,
    input wire logic        boot_busy,
    input wire logic [23:0] program_counter,
    input wire logic        mem_write,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] boot_internal_count,
    input wire logic        boot_channel_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Strobe shape and the byte address step at its rise
    property p_len; $fell(read_strobe_n) |->
        ##1 (!read_strobe_n)[*7] ##1 read_strobe_n; endproperty
    property p_step; $rose(read_strobe_n) |->
        ext_addr == $past(ext_addr) + 24'h000001; endproperty
    property p_sel; memory_select_n == 4'hf; endproperty
    property p_mirror; boot_memory_select_oe |->
        boot_memory_select_out_n == read_strobe_n; endproperty
    property p_oe; boot_memory_select_oe |->
        boot_mode == ebl_pkg::EBL_MODE_EPROM; endproperty
    property p_ready; host_ready |->
        boot_mode == ebl_pkg::EBL_MODE_HOST; endproperty
    property p_idle; boot_busy |-> program_counter == 24'h040004; endproperty
    property p_range; mem_write |-> mem_addr[23:8] == 16'h0400; endproperty
    // Completion must find the count spent and reach the vector promptly
    property p_end; boot_channel_interrupt |-> boot_internal_count == 16'h0000
        ##[0:3] program_counter == 24'h040050; endproperty
    property p_hold; boot_busy && $past(boot_busy) |->
        $stable(boot_mode); endproperty
    a_len: assert property (p_len)
        else $error("read strobe not low for 8 cycles");
    a_step: assert property (p_step)
        else $error("byte address did not step by one");
    a_sel: assert property (p_sel)
        else $error("another memory select went active");
    a_mirror: assert property (p_mirror)
        else $error("boot select does not follow the strobe");
    a_oe: assert property (p_oe)
        else $error("boot select driven outside EPROM boot");
    a_ready: assert property (p_ready)
        else $error("slave ready outside host boot");
    a_idle: assert property (p_idle)
        else $error("program counter left idle address while loading");
    a_range: assert property (p_range)
        else $error("word stored outside boot area");
    a_end: assert property (p_end)
        else $error("completion without empty count or vector");
    a_hold: assert property (p_hold)
        else $error("boot mode changed while loading");
    c_eprom: cover property (boot_channel_interrupt && boot_mode == 2'h1);
    c_host: cover property (boot_channel_interrupt && boot_mode == 2'h2);
    c_word: cover property (mem_write);
endmodule
bind ebl_boot_loader ebl_chk chk_u (.*);
`default_nettype wire

// ===== tb/ebl_eprom_model.sv
// Byte-wide boot EPROM answering the loader's read strobe
`timescale 1ns/1ps
`default_nettype none
module ebl_eprom_model (
    input wire logic        clk,
    input wire logic        cs,
    input wire logic        read_strobe_n,
    input wire logic [23:0] ext_addr,
    output logic [7:0]      data
);
    // Lines flip every cycle when not read, so a late sample shows
    initial data = 8'h00;
    always @(negedge clk) begin
        data <= (cs && !read_strobe_n) ?
            8'(ext_addr[10:0] + (ext_addr[10:0] >> 8)) : ~data;
    end
endmodule
`default_nettype wire

// ===== tb/ebl_boot_loader_tb.sv
// Self-checking bench for the boot loader
`timescale 1ns/1ps
`default_nettype none
module ebl_boot_loader_tb;
    logic        clk, srst, eprom_boot_select_pin, link_boot_select_pin;
    logic        boot_memory_select_in, host_write, host_wide, host_ready;
    logic        boot_memory_select_out_n, boot_memory_select_oe, mem_write;
    logic        read_strobe_n, boot_channel_interrupt, boot_busy, boot_done;
    logic [1:0]  boot_mode;
    logic [3:0]  memory_select_n;
    logic [7:0]  ext_data_hi;
    logic [15:0] host_data, boot_internal_count, boot_external_count;
    logic [23:0] ext_addr, mem_addr, boot_internal_index, program_counter;
    logic [31:0] boot_channel_control;
    logic [47:0] mem_data;
    int          mismatches = 0, n_tests = 0, nw = 0, i;
    ebl_boot_loader dut_u (.*);
    ebl_eprom_model mdl_u (.clk(clk), .read_strobe_n(read_strobe_n),
        .cs(boot_memory_select_oe && !boot_memory_select_out_n),
        .ext_addr(ext_addr), .data(ext_data_hi));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [7:0] b(input int n);
        return 8'(n + (n >> 8));
    endfunction
    function automatic logic [47:0] word(input int k);
        for (int j = 0; j < 6; j++) word[8*j +: 8] = b(6*k + j);
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Stored words must arrive in address order, bytes LSB first
    // Looked at on the falling edge, where the registered outputs are settled
    always @(negedge clk) begin
        if (mem_write === 1'b1) begin
            chk(48'(mem_addr), 48'h40000 + 48'(nw));
            chk(mem_data, word(nw));
            nw++;
        end
    end
    task automatic restart(input logic e, input logic l, input logic m);
        @(negedge clk);
        {srst, host_write, host_wide} = 3'h4;
        {eprom_boot_select_pin, link_boot_select_pin} = {e, l};
        boot_memory_select_in = m;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        nw = 0;
        chk(48'(program_counter), 48'h40004);
        repeat (4) @(negedge clk);
    endtask
    // Bounded wait for completion; a hang fails the word count
    task automatic wait_irq;
        i = 0;
        while (boot_channel_interrupt !== 1'b1 && i < 20000) begin
            @(negedge clk);
            i++;
        end
        chk(48'(nw), 48'h100);
        repeat (3) @(negedge clk);
        chk(48'(boot_done), 48'h1);
        chk(48'(program_counter), 48'h40050);
    endtask
    task automatic test_other;
        restart(1'b0, 1'b1, 1'b1);
        chk(48'(boot_memory_select_oe), 48'h0);
        chk(48'(boot_mode), 48'h0);
        $display("test link strap done");
    endtask
    task automatic test_eprom;
        restart(1'b1, 1'b0, 1'b1);
        chk(48'(boot_mode), 48'(ebl_pkg::EBL_MODE_EPROM));
        chk(48'(boot_channel_control), 48'h561);
        chk(48'(boot_internal_count), 48'h100);
        chk(48'(boot_external_count), 48'h600);
        chk(48'(boot_internal_index), 48'h40000);
        @(negedge clk);
        chk(48'(ext_addr), 48'h800000);
        chk(48'(memory_select_n), 48'hf);
        wait_irq();
        chk(48'(boot_external_count), 48'h0);
        chk(48'(boot_memory_select_oe), 48'h0);
        $display("test eprom done");
    endtask
    task automatic test_host;
        restart(1'b0, 1'b0, 1'b1);
        chk(48'(boot_mode), 48'(ebl_pkg::EBL_MODE_HOST));
        chk(48'(boot_channel_control), 48'h161);
        chk(48'(boot_internal_index), 48'h40000);
        chk(48'(boot_internal_count), 48'h100);
        eprom_boot_select_pin = 1'b1;
        @(negedge clk);
        chk(48'(host_ready), 48'h1);
        // Narrow half first with junk in the unused upper byte
        for (int n = 0; n < 768; n++) begin
            host_write = 1'b1;
            host_data = {~b(n), b(n)};
            @(negedge clk);
        end
        host_write = 1'b0;
        host_wide = 1'b1;
        @(negedge clk);
        for (int n = 768; n < 1536; n += 2) begin
            host_write = 1'b1;
            host_data = {b(n + 1), b(n)};
            @(negedge clk);
        end
        host_write = 1'b0;
        wait_irq();
        chk(48'(boot_mode), 48'(ebl_pkg::EBL_MODE_HOST));
        chk(48'(host_ready), 48'h0);
        host_write = 1'b1;
        repeat (12) @(negedge clk);
        host_write = 1'b0;
        chk(48'(nw), 48'h100);
        $display("test host done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        {host_write, host_wide, host_data} = '0;
        {eprom_boot_select_pin, link_boot_select_pin} = 2'h0;
        boot_memory_select_in = 1'b1;
        test_other();
        test_eprom();
        test_host();
        conclude();
    end
    initial begin
        #(30000 * 20);
        mismatches++;
        conclude();
    end
endmodule
`default_nettype wire
